// ### hdl/gpsel_consts.vh
`ifndef GPSEL_CONSTS_VH
`define GPSEL_CONSTS_VH
// ==========================================================
// Register offsets
`define GPSEL_OFS_RSVD32 7'h32
`define GPSEL_OFS_MPCTL 7'h33
`define GPSEL_OFS_RSVD34 7'h34
`define GPSEL_OFS_RSVD35 7'h35
`define GPSEL_OFS_SICTL 7'h36
`define GPSEL_OFS_RSVD37 7'h37
`define GPSEL_OFS_RSVD3B 7'h3b
`define GPSEL_OFS_PRGSEL 7'h3c
// ==========================================================
// Field positions
`define GPSEL_MP_FN_HI 5
`define GPSEL_MP_FN_LO 2
`define GPSEL_MP_IN_BIT 1
`define GPSEL_MP_OUT_BIT 0
`define GPSEL_SI_FN_HI 2
`define GPSEL_SI_FN_LO 1
`define GPSEL_SI_IN_BIT 0
// ==========================================================
// Reset values
`define GPSEL_RST_MPCTL 8'h00
`define GPSEL_RST_SICTL 8'h02
`define GPSEL_RST_PRGSEL 8'h01
`define GPSEL_RST_ZERO 8'h00
// ==========================================================
// Function codes
`define GPSEL_MP_OFF 4'h0
`define GPSEL_MP_INPUT 4'h1
`define GPSEL_MP_GENIN 4'h2
`define GPSEL_MP_GPO 4'h3
`define GPSEL_MP_DIVCLK 4'h4
`define GPSEL_MP_INTA 4'h5
`define GPSEL_MP_INTB 4'h6
`define GPSEL_MP_SBCLK 4'h8
`define GPSEL_MP_SWCLK 4'h9
`define GPSEL_SI_OFF 2'h0
`define GPSEL_SI_ON 2'h1
`define GPSEL_SI_GENIN 2'h2
// ==========================================================
// Interrupt pulse timing
`define GPSEL_INT_PULSE_US 2000
`define GPSEL_INT_PERIOD_US 4000
`define GPSEL_CLK_MHZ 50
`define GPSEL_INT_PULSE_CYC (`GPSEL_INT_PULSE_US * `GPSEL_CLK_MHZ)
`define GPSEL_INT_PERIOD_CYC (`GPSEL_INT_PERIOD_US * `GPSEL_CLK_MHZ)
`endif

// ### hdl/gpsel_pin_mux.v
`timescale 1ns/1ps
`include "gpsel_consts.vh"
module gpsel_pin_mux #(
   parameter PULSE_CYC = `GPSEL_INT_PULSE_CYC,
   parameter PERIOD_CYC = `GPSEL_INT_PERIOD_CYC
) (
   input wire clk_i,
   input wire reset_i,
   input wire [6:0] reg_addr_i,
   input wire reg_wr_i,
   input wire [7:0] reg_wdata_i,
   output reg [7:0] reg_rdata_o,
   input wire mp_pin_i,
   output reg mp_pin_o,
   output wire mp_pin_oe_n_o,
   output wire mp_in_en_o,
   output wire mp_sec_in_o,
   output wire mp_gen_in_o,
   input wire si_pin_i,
   output wire si_in_en_o,
   output wire si_audio_o,
   output wire si_gen_in_o,
   input wire divided_clock_output_i,
   input wire sec_bclk_i,
   input wire sec_wclk_i,
   input wire int_a_event_i,
   input wire int_a_multi_i,
   input wire int_b_event_i,
   input wire int_b_multi_i,
   input wire flags_read_i,
   output wire [4:0] prog_sel_o
);
   // ==========================================================
   // Registers
   reg [7:0] rsvd32;
   reg [7:0] rsvd35;
   reg [7:0] rsvd34;
   reg [1:0] mp_top;
   reg [3:0] mp_fn;
   reg mp_out_val;
   reg [4:0] si_top;
   reg [1:0] si_fn;
   reg [7:0] prg_sel;
   reg mp_s1, mp_s2, si_s1, si_s2;

   // ==========================================================
   // Address decode, shared by the write and read paths
   localparam SEL_NONE = 3'h0;
   localparam SEL_R32 = 3'h1;
   localparam SEL_MP = 3'h2;
   localparam SEL_R34 = 3'h3;
   localparam SEL_R35 = 3'h4;
   localparam SEL_SI = 3'h5;
   localparam SEL_PRG = 3'h6;

   function [2:0] reg_sel;
      input [6:0] addr;
      begin
         if (addr == `GPSEL_OFS_RSVD32) begin
            reg_sel = SEL_R32;
         end else if (addr == `GPSEL_OFS_MPCTL) begin
            reg_sel = SEL_MP;
         end else if (addr == `GPSEL_OFS_RSVD34) begin
            reg_sel = SEL_R34;
         end else if (addr == `GPSEL_OFS_RSVD35) begin
            reg_sel = SEL_R35;
         end else if (addr == `GPSEL_OFS_SICTL) begin
            reg_sel = SEL_SI;
         end else if (addr == `GPSEL_OFS_PRGSEL) begin
            reg_sel = SEL_PRG;
         end else begin
            // Reserved range 0x37..0x3b and holes decode to none
            reg_sel = SEL_NONE;
         end
      end
   endfunction

   wire [2:0] sel = reg_sel(reg_addr_i);

   // ==========================================================
   // Pin function decode, shared by enables and read-back
   function mp_senses;
      input [3:0] code;
      begin
         mp_senses = (code == `GPSEL_MP_INPUT) ||
            (code == `GPSEL_MP_GENIN);
      end
   endfunction

   function si_senses;
      input [1:0] code;
      begin
         si_senses = (code == `GPSEL_SI_ON) ||
            (code == `GPSEL_SI_GENIN);
      end
   endfunction

   always @(posedge clk_i) begin
      if (reset_i) begin
         rsvd32 <= `GPSEL_RST_ZERO;
         rsvd34 <= `GPSEL_RST_ZERO;
         rsvd35 <= `GPSEL_RST_ZERO;
         mp_top <= 2'h0;
         mp_fn <= `GPSEL_MP_OFF;
         mp_out_val <= 1'b0;
         si_top <= 5'h00;
         si_fn <= `GPSEL_SI_ON;
         prg_sel <= `GPSEL_RST_PRGSEL;
      end else if (reg_wr_i) begin
         // Read-only range 0x37..0x3b ignores writes
         if (sel == SEL_R32) begin
            rsvd32 <= reg_wdata_i;
         end else if (sel == SEL_MP) begin
            mp_top <= reg_wdata_i[7:6];
            mp_fn <= reg_wdata_i[`GPSEL_MP_FN_HI:`GPSEL_MP_FN_LO];
            mp_out_val <= reg_wdata_i[`GPSEL_MP_OUT_BIT];
         end else if (sel == SEL_R34) begin
            rsvd34 <= reg_wdata_i;
         end else if (sel == SEL_R35) begin
            rsvd35 <= reg_wdata_i;
         end else if (sel == SEL_SI) begin
            si_top <= reg_wdata_i[7:3];
            si_fn <= reg_wdata_i[`GPSEL_SI_FN_HI:`GPSEL_SI_FN_LO];
         end else if (sel == SEL_PRG) begin
            prg_sel <= reg_wdata_i;
         end
      end
   end

   // ==========================================================
   // Pin synchronisers; disabled buffers read as zero
   always @(posedge clk_i) begin
      if (reset_i) begin
         mp_s1 <= 1'b0;
         mp_s2 <= 1'b0;
         si_s1 <= 1'b0;
         si_s2 <= 1'b0;
      end else begin
         mp_s1 <= mp_pin_i;
         mp_s2 <= mp_s1;
         si_s1 <= si_pin_i;
         si_s2 <= si_s1;
      end
   end

   // ==========================================================
   // Multipurpose pin function decode
   assign mp_in_en_o = mp_senses(mp_fn);
   wire mp_lvl = mp_senses(mp_fn) & mp_s2;
   assign mp_sec_in_o = (mp_fn == `GPSEL_MP_INPUT) & mp_s2;
   assign mp_gen_in_o = (mp_fn == `GPSEL_MP_GENIN) & mp_s2;

   // Serial input pin decode
   assign si_in_en_o = si_senses(si_fn);
   wire si_lvl = si_senses(si_fn) & si_s2;
   assign si_audio_o = (si_fn == `GPSEL_SI_ON) & si_s2;
   assign si_gen_in_o = (si_fn == `GPSEL_SI_GENIN) & si_s2;

   assign prog_sel_o = prg_sel[4:0];

   // ==========================================================
   // Interrupt pulse generators, one per line
   wire int_a, int_b;
   gpsel_int_pulse #(.PULSE_CYC(PULSE_CYC), .PERIOD_CYC(PERIOD_CYC)) u_ia (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .event_i(int_a_event_i),
      .multi_i(int_a_multi_i),
      .ack_i(flags_read_i),
      .pulse_o(int_a)
   );
   gpsel_int_pulse #(.PULSE_CYC(PULSE_CYC), .PERIOD_CYC(PERIOD_CYC)) u_ib (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .event_i(int_b_event_i),
      .multi_i(int_b_multi_i),
      .ack_i(flags_read_i),
      .pulse_o(int_b)
   );

   // ==========================================================
   // Output mux; reserved codes float the pin
   reg mp_drv;
   always @* begin
      mp_drv = 1'b0;
      mp_pin_o = 1'b0;
      case (mp_fn)
         `GPSEL_MP_GPO: begin
            mp_drv = 1'b1;
            mp_pin_o = mp_out_val;
         end
         `GPSEL_MP_DIVCLK: begin
            mp_drv = 1'b1;
            mp_pin_o = divided_clock_output_i;
         end
         `GPSEL_MP_INTA: begin
            mp_drv = 1'b1;
            mp_pin_o = int_a;
         end
         `GPSEL_MP_INTB: begin
            mp_drv = 1'b1;
            mp_pin_o = int_b;
         end
         `GPSEL_MP_SBCLK: begin
            mp_drv = 1'b1;
            mp_pin_o = sec_bclk_i;
         end
         `GPSEL_MP_SWCLK: begin
            mp_drv = 1'b1;
            mp_pin_o = sec_wclk_i;
         end
         default: begin
            mp_drv = 1'b0;
            mp_pin_o = 1'b0;
         end
      endcase
   end
   assign mp_pin_oe_n_o = ~mp_drv;

   // ==========================================================
   // Read data, registered
   reg [7:0] next_rdata;
   always @* begin
      next_rdata = 8'h00;
      if (sel == SEL_R32) begin
         next_rdata = rsvd32;
      end else if (sel == SEL_MP) begin
         next_rdata = {mp_top, mp_fn, mp_lvl, mp_out_val};
      end else if (sel == SEL_R34) begin
         next_rdata = rsvd34;
      end else if (sel == SEL_R35) begin
         next_rdata = rsvd35;
      end else if (sel == SEL_SI) begin
         next_rdata = {si_top, si_fn, si_lvl};
      end else if (sel == SEL_PRG) begin
         next_rdata = prg_sel;
      end else begin
         // Undefined range and unmapped offsets read as zero
         next_rdata = 8'h00;
      end
   end

   always @(posedge clk_i) begin
      if (reset_i) begin
         reg_rdata_o <= 8'h00;
      end else begin
         reg_rdata_o <= next_rdata;
      end
   end
endmodule

// ==========================================================
// Interrupt pulse shaper
module gpsel_int_pulse #(
   parameter PULSE_CYC = `GPSEL_INT_PULSE_CYC,
   parameter PERIOD_CYC = `GPSEL_INT_PERIOD_CYC
) (
   input wire clk_i,
   input wire reset_i,
   input wire event_i,
   input wire multi_i,
   input wire ack_i,
   output wire pulse_o
);
   reg active;
   reg repeat_on;
   reg [31:0] cnt;
   always @(posedge clk_i) begin
      if (reset_i) begin
         active <= 1'b0;
         repeat_on <= 1'b0;
         cnt <= 32'h0;
      end else if (event_i && !active) begin
         active <= 1'b1;
         repeat_on <= multi_i;
         cnt <= 32'h0;
      end else if (active) begin
         // Event beats the acknowledge in the same cycle
         if (ack_i && !event_i) begin
            repeat_on <= 1'b0;
         end
         // A read in the gap ends the train; one in the gap's last cycle still lets one more pulse out
         if (!repeat_on && cnt >= PULSE_CYC - 1) begin
            active <= 1'b0;
            cnt <= 32'h0;
         end else if (cnt == PERIOD_CYC - 1) begin
            cnt <= 32'h0;
         end else begin
            cnt <= cnt + 32'h1;
         end
      end
   end
   assign pulse_o = active && (cnt < PULSE_CYC);
endmodule

// ### testbench/gpsel_pin_mux_sva.sv
`timescale 1ns/1ps
module gpsel_pin_mux_sva #(
   parameter PULSE_CYC = 4
) (
   input wire clk_i,
   input wire reset_i,
   input wire [6:0] reg_addr_i,
   input wire reg_wr_i,
   input wire [7:0] reg_wdata_i,
   input wire [7:0] reg_rdata_o,
   input wire mp_pin_o,
   input wire mp_pin_oe_n_o,
   input wire mp_in_en_o,
   input wire si_in_en_o,
   input wire divided_clock_output_i,
   input wire sec_bclk_i,
   input wire sec_wclk_i,
   input wire int_a_event_i,
   input wire int_a_multi_i,
   input wire [4:0] prog_sel_o
);
   // ==========================================================
   // Shadow copies, so the checks need no view inside
   reg [7:0] mp;
   reg [7:0] si;
   reg [7:0] prg;
   reg [31:0] hi_cnt;
   wire [3:0] fn = mp[5:2];
   wire drv = fn inside {4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9};
   always @(posedge clk_i) begin
      if (reset_i) begin
         mp <= 8'h00;
         si <= 8'h02;
         prg <= 8'h01;
      end else if (reg_wr_i) begin
         case (reg_addr_i)
            7'h33: mp <= reg_wdata_i;
            7'h36: si <= reg_wdata_i;
            7'h3c: prg <= reg_wdata_i;
            default: ;
         endcase
      end
   end
   always @(posedge clk_i) begin
      if (reset_i || !mp_pin_o)
         hi_cnt <= 32'h0;
      else
         hi_cnt <= hi_cnt + 32'h1;
   end
   // ==========================================================
   // Checks
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   a_drive_only_out: assert property (mp_pin_oe_n_o == !drv)
      else $error("pin driver enable wrong");
   a_off_quiet: assert property (fn == 4'h0 |-> mp_pin_oe_n_o && !mp_in_en_o)
      else $error("disabled pin not quiet");
   a_input_en: assert property (mp_in_en_o == (fn == 4'h1 || fn == 4'h2))
      else $error("pin input buffer wrong");
   a_gpo_value: assert property (fn == 4'h3 |-> mp_pin_o == mp[0])
      else $error("general output wrong");
   a_clk_route: assert property (fn == 4'h4 |-> mp_pin_o == divided_clock_output_i)
      else $error("divided clock not routed");
   a_sec_clocks: assert property ((fn == 4'h8 |-> mp_pin_o == sec_bclk_i) and (fn == 4'h9 |-> mp_pin_o == sec_wclk_i))
      else $error("secondary clock not routed");
   a_int_start: assert property (fn == 4'h5 && int_a_event_i && !int_a_multi_i && !mp_pin_o && !reg_wr_i |=> mp_pin_o)
      else $error("interrupt pulse missing");
   a_pulse_width: assert property ($fell(mp_pin_o) && fn == 4'h5 && $past(fn) == 4'h5 |-> hi_cnt == PULSE_CYC)
      else $error("interrupt pulse width wrong");
   a_si_enable: assert property (si_in_en_o == (si[2:1] == 2'h1 || si[2:1] == 2'h2))
      else $error("serial input buffer wrong");
   a_prog_follow: assert property (prog_sel_o == prg[4:0])
      else $error("program select wrong");
   a_read_back: assert property (!$past(reset_i) && $past(reg_addr_i) == 7'h3c |-> reg_rdata_o == $past(prg))
      else $error("read data wrong");
   c_gpo: cover property (fn == 4'h3 && mp_pin_o);
   c_int: cover property ($fell(mp_pin_o) && fn == 4'h5);
   c_last: cover property (prog_sel_o == 5'h19);
endmodule

// ### testbench/gpsel_ext_logic.sv
`timescale 1ns/1ps
// ==========================================================
// System logic on the multipurpose pin
module gpsel_ext_logic (
   input wire pin_o_i,
   input wire oe_n_i,
   input wire level_i,
   output wire pin_i_o
);
   // Drives the wire only while the block lets go
   assign pin_i_o = oe_n_i ? level_i : pin_o_i;
endmodule

// ### testbench/test_gpsel_pin_mux.sv
`timescale 1ns/1ps
module test_gpsel_pin_mux;
   reg clk_i = 0, reset_i = 1, reg_wr_i = 0, lvl = 1, si_pin_i = 0;
   reg divided_clock_output_i = 1, sec_bclk_i = 0, sec_wclk_i = 1;
   reg int_a_event_i = 0, int_a_multi_i = 0, flags_read_i = 0;
   reg int_b_event_i = 0, int_b_multi_i = 0;
   reg [6:0] reg_addr_i = 7'h00;
   reg [7:0] reg_wdata_i = 8'h00;
   wire [7:0] reg_rdata_o;
   wire [4:0] prog_sel_o;
   wire mp_pin_i, mp_pin_o, mp_pin_oe_n_o, mp_in_en_o, mp_sec_in_o;
   wire mp_gen_in_o, si_in_en_o, si_audio_o, si_gen_in_o;
   integer fails = 0, n_tests = 0, cyc = 0, i, k, n;
   always #10 clk_i = ~clk_i;
   // Short pulse figures keep the run brief
   gpsel_pin_mux #(.PULSE_CYC(4), .PERIOD_CYC(8)) DUT (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .reg_addr_i(reg_addr_i),
      .reg_wr_i(reg_wr_i),
      .reg_wdata_i(reg_wdata_i),
      .reg_rdata_o(reg_rdata_o),
      .mp_pin_i(mp_pin_i),
      .mp_pin_o(mp_pin_o),
      .mp_pin_oe_n_o(mp_pin_oe_n_o),
      .mp_in_en_o(mp_in_en_o),
      .mp_sec_in_o(mp_sec_in_o),
      .mp_gen_in_o(mp_gen_in_o),
      .si_pin_i(si_pin_i),
      .si_in_en_o(si_in_en_o),
      .si_audio_o(si_audio_o),
      .si_gen_in_o(si_gen_in_o),
      .divided_clock_output_i(divided_clock_output_i),
      .sec_bclk_i(sec_bclk_i),
      .sec_wclk_i(sec_wclk_i),
      .int_a_event_i(int_a_event_i),
      .int_a_multi_i(int_a_multi_i),
      .int_b_event_i(int_b_event_i),
      .int_b_multi_i(int_b_multi_i),
      .flags_read_i(flags_read_i),
      .prog_sel_o(prog_sel_o)
   );
   gpsel_ext_logic u_ext (.pin_o_i(mp_pin_o), .oe_n_i(mp_pin_oe_n_o),
      .level_i(lvl), .pin_i_o(mp_pin_i));
   // ==========================================================
   // Helpers
   task chk(input string nm, input logic [7:0] seen, input logic [7:0] e);
      n_tests = n_tests + 1;
      if (seen !== e) begin
         fails = fails + 1;
         $display("mismatch %s expected %h seen %h", nm, e, seen);
      end
   endtask
   task wr(input logic [6:0] a, input logic [7:0] d);
      @(negedge clk_i);
      reg_addr_i = a;
      reg_wdata_i = d;
      reg_wr_i = 1;
      @(negedge clk_i);
      reg_wr_i = 0;
   endtask
   task rd(input string nm, input logic [6:0] a, input logic [7:0] e);
      @(negedge clk_i);
      reg_addr_i = a;
      @(negedge clk_i);
      chk(nm, reg_rdata_o, e);
   endtask
   task tally_and_finish;
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cyc = cyc + 1;
      if (cyc == 3000) begin
         fails = fails + 1;
         tally_and_finish;
      end
   end
   // ==========================================================
   // Scenarios
   task t_reset;
      chk("oe_n", mp_pin_oe_n_o, 1);
      rd("mp", 7'h33, 8'h00);
      rd("si", 7'h36, 8'h02);
      rd("prog", 7'h3c, 8'h01);
      rd("r32", 7'h32, 8'h00);
      rd("r37", 7'h37, 8'h00);
   endtask
   task t_modes;
      for (i = 0; i < 9; i = i + 1) begin
         k = (i < 7) ? i : i + 1;
         wr(7'h33, {2'b00, k[3:0], 2'b00});
         repeat (3) @(negedge clk_i);
         chk("oe_n", mp_pin_oe_n_o, !(k inside {3, 4, 5, 6, 8, 9}));
         chk("in_en", mp_in_en_o, k == 1 || k == 2);
         chk("sec", mp_sec_in_o, k == 1);
         chk("gen_in", mp_gen_in_o, k == 2);
         if (k > 2)
            chk("pin", mp_pin_o, k == 4 || k == 9);
         rd("mp", 7'h33, {2'b00, k[3:0], k == 1 || k == 2, 1'b0});
      end
      // Low pin level must reach the general input and D1
      wr(7'h33, 8'h08);
      lvl = 0;
      repeat (3) @(negedge clk_i);
      chk("gen_in", mp_gen_in_o, 0);
      rd("mp", 7'h33, 8'h08);
      lvl = 1;
      // D1 is read-only, a written one must not show
      wr(7'h33, 8'h0f);
      chk("gpo", mp_pin_o, 1);
      rd("mp", 7'h33, 8'h0d);
   endtask
   task t_si;
      si_pin_i = 1;
      for (k = 0; k < 3; k = k + 1) begin
         wr(7'h36, {5'h0, k[1:0], 1'b1});
         repeat (3) @(negedge clk_i);
         chk("si_en", si_in_en_o, k != 0);
         chk("si_aud", si_audio_o, k == 1);
         chk("si_gen_in", si_gen_in_o, k == 2);
         rd("si", 7'h36, {5'h0, k[1:0], k != 0});
      end
      si_pin_i = 0;
      repeat (3) @(negedge clk_i);
      chk("si_gen_in", si_gen_in_o, 0);
      rd("si", 7'h36, 8'h04);
   endtask
   task t_prog;
      for (k = 1; k <= 25; k = k + 24) begin
         wr(7'h3c, k[7:0]);
         chk("prog", prog_sel_o, k[4:0]);
         rd("prog", 7'h3c, k[7:0]);
      end
   endtask
   task t_int;
      wr(7'h33, 8'h14);
      n = 0;
      int_a_event_i = 1;
      repeat (20) begin
         @(negedge clk_i);
         int_a_event_i = 0;
         n = n + mp_pin_o;
      end
      chk("one", n[7:0], 8'h04);
      wr(7'h33, 8'h18);
      n = 0;
      int_b_multi_i = 1;
      int_b_event_i = 1;
      repeat (24) begin
         @(negedge clk_i);
         int_b_event_i = 0;
         n = n + mp_pin_o;
      end
      chk("rep", n[7:0], 8'h0c);
      flags_read_i = 1;
      @(negedge clk_i);
      flags_read_i = 0;
      repeat (8) @(negedge clk_i);
      n = 0;
      repeat (16) begin
         @(negedge clk_i);
         n = n + mp_pin_o;
      end
      chk("stop", n[7:0], 8'h00);
   endtask
   initial begin
      repeat (2) @(negedge clk_i);
      reset_i = 0;
      t_reset;
      t_modes;
      t_si;
      t_prog;
      t_int;
      tally_and_finish;
   end
endmodule
bind gpsel_pin_mux gpsel_pin_mux_sva #(.PULSE_CYC(PULSE_CYC)) u_sva (
   .clk_i(clk_i),
   .reset_i(reset_i),
   .reg_addr_i(reg_addr_i),
   .reg_wr_i(reg_wr_i),
   .reg_wdata_i(reg_wdata_i),
   .reg_rdata_o(reg_rdata_o),
   .mp_pin_o(mp_pin_o),
   .mp_pin_oe_n_o(mp_pin_oe_n_o),
   .mp_in_en_o(mp_in_en_o),
   .si_in_en_o(si_in_en_o),
   .divided_clock_output_i(divided_clock_output_i),
   .sec_bclk_i(sec_bclk_i),
   .sec_wclk_i(sec_wclk_i),
   .int_a_event_i(int_a_event_i),
   .int_a_multi_i(int_a_multi_i),
   .prog_sel_o(prog_sel_o)
);
